// File: rtl/pmsc_pkg.sv
// Purpose: Shared constants and types for the power management status/control block.
// Assumes: 8-bit register port, single 100 MHz clock domain.
// Notes:   Register offsets and the interrupt register layout are local choices.
package pmsc_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 3'h3;

  // ----------------------------------------------------------------------
  // Field positions, first control register
  // ----------------------------------------------------------------------
  localparam int unsigned B1_WARN_FLAG  = 7;
  localparam int unsigned B1_WARN_ACK   = 6;
  localparam int unsigned B1_WARN_IE    = 5;
  localparam int unsigned B1_DET_RST_EN = 4;
  localparam int unsigned B1_DET_STP_EN = 3;
  localparam int unsigned B1_DET_EN     = 2;
  localparam int unsigned B1_BG_BUF_EN  = 0;

  // ----------------------------------------------------------------------
  // Field positions, second control register
  // ----------------------------------------------------------------------
  localparam int unsigned B2_DET_VSEL  = 5;
  localparam int unsigned B2_WARN_VSEL = 4;
  localparam int unsigned B2_PPD_FLAG  = 3;
  localparam int unsigned B2_PPD_ACK   = 2;
  localparam int unsigned B2_PPD_CTRL  = 0;

  // Interrupt status/mask layout.
  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IB_WARN    = 0;
  localparam int unsigned IB_DETECT  = 1;
  localparam int unsigned IB_PPD_REC = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_CTRL_ONE = 8'h1c;
  localparam logic [DATA_W-1:0] RST_CTRL_TWO = 8'h00;
  localparam logic [IRQ_W-1:0]  RST_IRQ_MASK = 3'h0;

  // Sampled analog and mode inputs.
  typedef struct packed {
    logic warn_below;     // Supply below warning trip point.
    logic detect_below;   // Supply below detect trip point.
    logic in_stop;        // Device is in a stop mode.
    logic deep_recovered; // Pulse-like level: wake from deep stop mode.
  } pmsc_analog_s;

  // Register port request.
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pmsc_req_s;

endpackage : pmsc_pkg

// File: rtl/pmsc_sync.sv
// Purpose: Three-stage synchroniser with second/third agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes:   Stage one feeds only stage two.
`timescale 1ns/1ps
module pmsc_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (clk_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is accepted only once two settled stages agree.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sync_out[gi] <= 1'b0;
        end else if (clk_en && (s2_q[gi] == s3_q[gi])) begin
          sync_out[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

endmodule // pmsc_sync

// File: rtl/pmsc_ctrl.sv
// Purpose: Power management status and control registers with supervision logic.
// Assumes: CPU drives a one-cycle strobe register port on clk; analog inputs async.
// Notes:   Read data stand for exactly one cycle after the read strobe.
//          A low clock enable freezes every register, read data included.
//          The detect reset request is a level; the reset controller owns its timing.
//
// Functional notes
// - Warning flag sets on low supply, sticky.
// - Write-once bits accept only first write.
// - Warning ack clears flag if condition gone.
// - Warning interrupt enable gates interrupt request.
// - Detect reset enable forces chip reset.
// - Detect stop enable keeps detection in stop.
// - Detect enable qualifies detect logic and controls.
// - Bandgap buffer enable drives buffer on.
// - Select bits choose detect and warning points.
// - Detect:warning code picks one of four levels.
// - Partial powerdown flag set after deep stop.
// - Partial powerdown ack clears the flag.
// - Powerdown control selects deep or light stop.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module pmsc_ctrl
  import pmsc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     clk_en,
  input  wire pmsc_pkg::pmsc_req_s      req,
  output logic [pmsc_pkg::DATA_W-1:0]   rdata,
  input  wire pmsc_pkg::pmsc_analog_s   analog_in,
  output logic                          irq,
  output logic                          warn_irq_req,
  output logic                          chip_reset_req,
  output logic                          detect_active,
  output logic                          bandgap_buffer_on,
  output logic [1:0]                    trip_code,
  output logic                          deep_stop_select,
  output logic                          io_access_blocked
);
  import pmsc_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  // All four supervision inputs share one synchroniser. A one-cycle pulse is filtered
  // out, so the wake indication from deep stop must last at least two cycles.
  pmsc_analog_s ana;

  pmsc_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .clk_en   (clk_en),
    .async_in (analog_in),
    .sync_out (ana)
  );

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic             low_warn_flag_q;
  logic             low_warn_irq_enable_q;
  logic             low_detect_reset_enable_q;
  logic             low_detect_stop_enable_q;
  logic             low_detect_enable_q;
  logic             bandgap_buffer_enable_q;
  logic             detect_voltage_select_q;
  logic             warn_voltage_select_q;
  logic             partial_powerdown_flag_q;
  logic             partial_powerdown_control_q;
  logic             once_one_done_q;
  logic             once_two_done_q;
  logic             warn_prev_q;
  logic             deep_prev_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;

  logic wr_one;
  logic wr_two;
  logic warn_rise;
  logic detect_event;
  logic deep_rise;
  logic warn_ack;
  logic ppd_ack;

  assign wr_one    = clk_en && req.wr && (req.addr == OFF_CTRL_ONE);
  assign wr_two    = clk_en && req.wr && (req.addr == OFF_CTRL_TWO);
  assign warn_ack  = wr_one && req.wdata[B1_WARN_ACK];
  assign ppd_ack   = wr_two && req.wdata[B2_PPD_ACK];
  assign warn_rise = ana.warn_below && !warn_prev_q;
  assign deep_rise = ana.deep_recovered && !deep_prev_q;

  // Detection runs when enabled, and in stop only with the stop enable.
  assign detect_event = low_detect_enable_q && ana.detect_below &&
                        (!ana.in_stop || low_detect_stop_enable_q);

  // ----------------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------------
  // History resets low, so a level already present at reset is seen as a rise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      warn_prev_q <= 1'b0;
      deep_prev_q <= 1'b0;
    end else if (clk_en) begin
      warn_prev_q <= ana.warn_below;
      deep_prev_q <= ana.deep_recovered;
    end
  end

  // ----------------------------------------------------------------------
  // Control register one
  // ----------------------------------------------------------------------
  // Reset-time supply state is caught because the flag sets on the warn_below level, not only on warn_rise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_warn_flag_q <= RST_CTRL_ONE[B1_WARN_FLAG];
    end else if (clk_en) begin
      if (warn_rise || ana.warn_below) begin
        low_warn_flag_q <= 1'b1;
      end else if (warn_ack) begin
        low_warn_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_warn_irq_enable_q    <= RST_CTRL_ONE[B1_WARN_IE];
      low_detect_stop_enable_q <= RST_CTRL_ONE[B1_DET_STP_EN];
      bandgap_buffer_enable_q  <= RST_CTRL_ONE[B1_BG_BUF_EN];
    end else if (wr_one) begin
      low_warn_irq_enable_q    <= req.wdata[B1_WARN_IE];
      low_detect_stop_enable_q <= req.wdata[B1_DET_STP_EN];
      bandgap_buffer_enable_q  <= req.wdata[B1_BG_BUF_EN];
    end
  end

  // Write-once fields lock on the first write to their register.
  // The lock keeps whatever data that write carried, until the next reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_detect_reset_enable_q <= RST_CTRL_ONE[B1_DET_RST_EN];
      low_detect_enable_q       <= RST_CTRL_ONE[B1_DET_EN];
      once_one_done_q           <= 1'b0;
    end else if (wr_one && !once_one_done_q) begin
      low_detect_reset_enable_q <= req.wdata[B1_DET_RST_EN];
      low_detect_enable_q       <= req.wdata[B1_DET_EN];
      once_one_done_q           <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Control register two
  // ----------------------------------------------------------------------
  // Trip-point selects stay writable; only the stop-mode choice is write-once.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      detect_voltage_select_q <= RST_CTRL_TWO[B2_DET_VSEL];
      warn_voltage_select_q   <= RST_CTRL_TWO[B2_WARN_VSEL];
    end else if (wr_two) begin
      detect_voltage_select_q <= req.wdata[B2_DET_VSEL];
      warn_voltage_select_q   <= req.wdata[B2_WARN_VSEL];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      partial_powerdown_control_q <= RST_CTRL_TWO[B2_PPD_CTRL];
      once_two_done_q             <= 1'b0;
    end else if (wr_two && !once_two_done_q) begin
      partial_powerdown_control_q <= req.wdata[B2_PPD_CTRL];
      once_two_done_q             <= 1'b1;
    end
  end

  // Recovery wins over a same-cycle acknowledge so no wake is lost.
  // While set, the flag keeps I/O access blocked until software acknowledges it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      partial_powerdown_flag_q <= RST_CTRL_TWO[B2_PPD_FLAG];
    end else if (clk_en) begin
      if (deep_rise) begin
        partial_powerdown_flag_q <= 1'b1;
      end else if (ppd_ack) begin
        partial_powerdown_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_events;
  logic             stat_rd;
  logic             mask_wr;

  assign irq_events = {deep_rise, detect_event, warn_rise};
  assign stat_rd    = clk_en && req.rd && (req.addr == OFF_IRQ_STAT);
  assign mask_wr    = clk_en && req.wr && (req.addr == OFF_IRQ_MASK);

  // Set wins over the read-to-clear in the same cycle.
  // The detect event is a level, so its bit re-arms every cycle the supply stays low while detection is qualified.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= '0;
    end else if (clk_en) begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_events;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= RST_IRQ_MASK;
    end else if (mask_wr) begin
      irq_mask_q <= req.wdata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  // Unmapped offsets and the write-only strobe bits fall through to zero.
  always_comb begin
    rd_mux = '0;
    unique case (req.addr)
      OFF_CTRL_ONE: begin
        rd_mux[B1_WARN_FLAG]  = low_warn_flag_q;
        rd_mux[B1_WARN_IE]    = low_warn_irq_enable_q;
        rd_mux[B1_DET_RST_EN] = low_detect_reset_enable_q;
        rd_mux[B1_DET_STP_EN] = low_detect_stop_enable_q;
        rd_mux[B1_DET_EN]     = low_detect_enable_q;
        rd_mux[B1_BG_BUF_EN]  = bandgap_buffer_enable_q;
      end
      OFF_CTRL_TWO: begin
        rd_mux[B2_DET_VSEL]   = detect_voltage_select_q;
        rd_mux[B2_WARN_VSEL]  = warn_voltage_select_q;
        rd_mux[B2_PPD_FLAG]   = partial_powerdown_flag_q;
        rd_mux[B2_PPD_CTRL]   = partial_powerdown_control_q;
      end
      OFF_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
      OFF_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:      rd_mux = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  // Zero between answers lets several slaves share one OR-ed read bus.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (clk_en) begin
      rdata <= req.rd ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Interrupt lines follow their sources one cycle late.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq          <= 1'b0;
      warn_irq_req <= 1'b0;
    end else if (clk_en) begin
      irq          <= |(irq_stat_q & irq_mask_q);
      warn_irq_req <= low_warn_irq_enable_q && low_warn_flag_q;
    end
  end

  // Detection qualifiers apply to both the active indication and the reset request.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chip_reset_req <= 1'b0;
      detect_active  <= 1'b0;
    end else if (clk_en) begin
      chip_reset_req <= detect_event && low_detect_reset_enable_q;
      detect_active  <= low_detect_enable_q &&
                        (!ana.in_stop || low_detect_stop_enable_q);
    end
  end

  // Analog controls and the stop-mode choice are plain registered copies.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bandgap_buffer_on <= 1'b0;
      trip_code         <= 2'b00;
      deep_stop_select  <= 1'b0;
      io_access_blocked <= 1'b0;
    end else if (clk_en) begin
      bandgap_buffer_on <= bandgap_buffer_enable_q;
      trip_code         <= {detect_voltage_select_q,
                            warn_voltage_select_q};
      deep_stop_select  <= partial_powerdown_control_q;
      io_access_blocked <= partial_powerdown_flag_q;
    end
  end

endmodule // pmsc_ctrl

// File: tb/pmsc_ctrl_assertions.sv
// Purpose: Port-level checks for the power management status/control block.
// Assumes: One clock; resetn asynchronous, active low.
// Notes:   Analog paths have sync latency, so checks tie outputs to bus writes.
`timescale 1ns/1ps
module pmsc_ctrl_checker
  import pmsc_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          resetn,
  input wire logic                          clk_en,
  input wire pmsc_pkg::pmsc_req_s           req,
  input wire logic [pmsc_pkg::DATA_W-1:0]   rdata,
  input wire logic                          irq,
  input wire logic                          warn_irq_req,
  input wire logic                          chip_reset_req,
  input wire logic                          detect_active,
  input wire logic                          bandgap_buffer_on,
  input wire logic [1:0]                    trip_code,
  input wire logic                          deep_stop_select
);
  logic       wr_one;
  logic       wr_two;
  logic [1:0] two_cnt_q;

  assign wr_one = clk_en && req.wr && (req.addr == OFF_CTRL_ONE);
  assign wr_two = clk_en && req.wr && (req.addr == OFF_CTRL_TWO);

  // Counts to three after the first write to control two, when its lock must hold.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      two_cnt_q <= 2'h0;
    end else if (wr_two && two_cnt_q == 2'h0) begin
      two_cnt_q <= 2'h1;
    end else if (two_cnt_q != 2'h0 && two_cnt_q != 2'h3) begin
      two_cnt_q <= two_cnt_q + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_rdata_idle_zero: assert property ($past(clk_en) && !$past(req.rd)
    |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_one_ack_zero: assert property ($past(clk_en && req.rd && req.addr == OFF_CTRL_ONE)
    |-> rdata[6] == 1'b0 && rdata[1] == 1'b0)
    else $error("control one strobe or unused bit read as one");
  chk_two_unused_zero: assert property ($past(clk_en && req.rd && req.addr == OFF_CTRL_TWO)
    |-> rdata[7:6] == 2'b00 && rdata[2:1] == 2'b00)
    else $error("control two strobe or unused bit read as one");
  chk_unmapped_read_zero: assert property ($past(clk_en && req.rd && req.addr[2])
    |-> rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  chk_reset_needs_detect: assert property (chip_reset_req |-> detect_active)
    else $error("chip reset requested while detection inactive");
  chk_trip_by_write: assert property ($changed(trip_code)
    |-> $past(wr_two) || $past(wr_two, 2))
    else $error("trip code changed without a control two write");
  chk_bandgap_by_write: assert property ($changed(bandgap_buffer_on)
    |-> $past(wr_one) || $past(wr_one, 2))
    else $error("bandgap buffer changed without a control one write");
  chk_stop_mode_lock: assert property (two_cnt_q == 2'h3
    |-> $stable(deep_stop_select))
    else $error("stop mode select changed after its first write");

  cov_chip_reset: cover property ($rose(chip_reset_req));
  cov_irq: cover property ($rose(irq));
  cov_warn_irq: cover property ($rose(warn_irq_req));
endmodule // pmsc_ctrl_checker

bind pmsc_ctrl pmsc_ctrl_checker chk_u (
  .clk(clk), .resetn(resetn), .clk_en(clk_en), .req(req), .rdata(rdata), .irq(irq),
  .warn_irq_req(warn_irq_req), .chip_reset_req(chip_reset_req),
  .detect_active(detect_active), .bandgap_buffer_on(bandgap_buffer_on),
  .trip_code(trip_code), .deep_stop_select(deep_stop_select)
);

// File: tb/pmsc_ctrl_tb.sv
// Purpose: Self-checking bench for the power management status/control block.
// Assumes: Analog inputs settle through the synchroniser within eight cycles.
// Notes:   Three resets cover write-once locks with different first writes.
`timescale 1ns/1ps
module pmsc_ctrl_tb;
  import pmsc_pkg::*;
  logic         clk;
  logic         resetn;
  logic         clk_en;
  pmsc_req_s    req;
  pmsc_analog_s analog_in;
  logic [7:0]   rdata;
  logic         irq;
  logic         warn_irq_req;
  logic         chip_reset_req;
  logic         detect_active;
  logic         bandgap_buffer_on;
  logic [1:0]   trip_code;
  logic         deep_stop_select;
  logic         io_access_blocked;
  logic [1:0]   code;
  int           n_mismatch;
  int           tests_run;

  pmsc_ctrl dut_u (
    .clk(clk), .resetn(resetn), .clk_en(clk_en), .req(req), .rdata(rdata),
    .analog_in(analog_in), .irq(irq), .warn_irq_req(warn_irq_req),
    .chip_reset_req(chip_reset_req), .detect_active(detect_active),
    .bandgap_buffer_on(bandgap_buffer_on), .trip_code(trip_code),
    .deep_stop_select(deep_stop_select), .io_access_blocked(io_access_blocked)
  );

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  // Strobes drop one edge before the next request, so no signal is set twice at once.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rdata, exp);
    @(posedge clk);
  endtask

  task automatic settle;
    repeat (8) @(posedge clk);
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    resetn = 1'b0;
    clk_en = 1'b1;
    req = '0;
    analog_in = '0;
    do_reset();
    rd_chk(OFF_CTRL_ONE, RST_CTRL_ONE);
    rd_chk(OFF_CTRL_TWO, RST_CTRL_TWO);
    rd_chk(OFF_IRQ_MASK, 8'h00);
    rd_chk(3'h5, 8'h00);
    chk1(detect_active, 1'b1);
    wr(OFF_CTRL_ONE, 8'hed);
    rd_chk(OFF_CTRL_ONE, 8'h2d);
    chk1(bandgap_buffer_on, 1'b1);
    wr(OFF_CTRL_ONE, 8'h10);
    rd_chk(OFF_CTRL_ONE, 8'h04);
    chk1(bandgap_buffer_on, 1'b0);
    analog_in.detect_below <= 1'b1;
    settle();
    chk1(chip_reset_req, 1'b0);
    analog_in.warn_below <= 1'b1;
    settle();
    rd_chk(OFF_CTRL_ONE, 8'h84);
    chk1(warn_irq_req, 1'b0);
    wr(OFF_CTRL_ONE, 8'h24);
    settle();
    chk1(warn_irq_req, 1'b1);
    wr(OFF_CTRL_ONE, 8'h64);
    rd_chk(OFF_CTRL_ONE, 8'ha4);
    analog_in.detect_below <= 1'b0;
    analog_in.warn_below <= 1'b0;
    settle();
    rd_chk(OFF_CTRL_ONE, 8'ha4);
    wr(OFF_CTRL_ONE, 8'h64);
    rd_chk(OFF_CTRL_ONE, 8'h24);
    chk1(warn_irq_req, 1'b0);
    chk1(irq, 1'b0);
    wr(OFF_IRQ_MASK, 8'h01);
    rd_chk(OFF_IRQ_MASK, 8'h01);
    clk_en <= 1'b0;
    wr(OFF_IRQ_MASK, 8'h07);
    clk_en <= 1'b1;
    rd_chk(OFF_IRQ_MASK, 8'h01);
    chk1(irq, 1'b1);
    rd_chk(OFF_IRQ_STAT, 8'h03);
    settle();
    chk1(irq, 1'b0);
    rd_chk(OFF_IRQ_STAT, 8'h00);
    wr(OFF_CTRL_TWO, 8'hff);
    rd_chk(OFF_CTRL_TWO, 8'h31);
    check({6'h00, trip_code}, 8'h03);
    chk1(deep_stop_select, 1'b1);
    for (int i = 0; i < 4; i++) begin
      code = i[1:0];
      wr(OFF_CTRL_TWO, {2'b00, code, 4'h0});
      rd_chk(OFF_CTRL_TWO, {2'b00, code, 4'h1});
      check({6'h00, trip_code}, {6'h00, code});
    end
    analog_in.deep_recovered <= 1'b1;
    settle();
    analog_in.deep_recovered <= 1'b0;
    settle();
    rd_chk(OFF_CTRL_TWO, 8'h39);
    chk1(io_access_blocked, 1'b1);
    rd_chk(OFF_IRQ_STAT, 8'h04);
    wr(OFF_CTRL_TWO, 8'h34);
    rd_chk(OFF_CTRL_TWO, 8'h31);
    chk1(io_access_blocked, 1'b0);
    do_reset();
    wr(OFF_CTRL_ONE, 8'h14);
    analog_in.detect_below <= 1'b1;
    settle();
    chk1(chip_reset_req, 1'b1);
    analog_in.in_stop <= 1'b1;
    settle();
    chk1(detect_active, 1'b0);
    chk1(chip_reset_req, 1'b0);
    wr(OFF_CTRL_ONE, 8'h18);
    settle();
    chk1(detect_active, 1'b1);
    chk1(chip_reset_req, 1'b1);
    rd_chk(OFF_CTRL_ONE, 8'h1c);
    analog_in.in_stop <= 1'b0;
    analog_in.warn_below <= 1'b1;
    do_reset();
    settle();
    rd_chk(OFF_CTRL_ONE, 8'h9c);
    wr(OFF_CTRL_ONE, 8'h10);
    rd_chk(OFF_CTRL_ONE, 8'h90);
    settle();
    chk1(detect_active, 1'b0);
    chk1(chip_reset_req, 1'b0);
    end_sim();
  end
endmodule // pmsc_ctrl_tb
